//--- sep_eeprom_dev.sv
// Word store end: sixteen 16-bit words behind a three-wire serial link
// Assumes the host drives chip select, serial clock and serial input
// What this block does
// - Sixteen words of sixteen bits, 4-bit address
// - Instruction is start bit, opcode, address
// - Leading zeros skipped; first one is start
// - 10xx read, 01xx write, 11xx erase
// - Data out driven only during read
// - Read sends zero dummy, then sixteen bits
// - Read bits change on serial clock rise
// - Programming refused until enabled, until disabled
// - Read works whether enabled or not
// - Erase starts on select fall, word ones
// - Host holds select high one period after programming
// - Standby when select low, not programming
// - Write takes sixteen data bits into word
// - Programming lasts while select stays low
// - Host ends programming with select high
// - Erase all sets every word to ones
// - Write all stores data in every word
// - Host may stop clock during programming
// - Host holds programming ten to thirty ms
// - Select low one microsecond between instructions
// - Serial clock period at least four microseconds
`timescale 1ns/10ps
`default_nettype none

module sep_eeprom_dev (
  sep_link_if.dev link,
  input wire logic clk_in,
  input wire logic srst_in,
  output logic standby_out,
  output logic hv_on_out,
  output logic prog_en_out
);
  import sep_pkg::*;

  // Link-side state, clocked by the serial clock
  logic link_rst;
  sep_link_st_t state_reg;
  logic [4:0] cnt_reg;
  logic [7:0] instr_reg;
  logic [SEP_WORD_W-1:0] rd_shift_reg;
  logic out_reg;
  logic oe_reg;
  logic armed_reg;
  logic [SEP_OPC_W-1:0] op_reg;
  logic [SEP_ADDR_W-1:0] addr_reg;
  logic [SEP_WORD_W-1:0] data_reg;

  // Decode of the instruction as its last bit arrives
  logic [7:0] full_instr;
  logic [SEP_OPC_W-1:0] full_op;
  logic [SEP_ADDR_W-1:0] full_addr;
  logic instr_last;
  logic data_last;
  logic full_is_read;
  logic full_has_data;

  // Core-side state, clocked by clk_in
  logic [SEP_WORD_W-1:0] mem_reg [SEP_WORDS];
  logic cs_s;
  logic armed_s;
  logic cs_prev_reg;
  logic used_reg;
  logic prog_en_reg;
  logic prog_active_reg;
  logic standby_reg;
  logic commit;
  logic do_prog;
  logic op_read;
  logic op_write;
  logic op_erase;
  logic op_en;
  logic op_dis;
  logic op_erase_all_cmd;
  logic op_write_all_cmd;
  logic op_is_prog;

  // ---------------- Link side ----------------

  // Deselect clears the sequencer, so every frame starts from scratch
  assign link_rst = srst_in | ~link.chip_sel;

  assign full_instr = {instr_reg[6:0], link.serial_in};
  assign full_op = full_instr[7:4];
  assign full_addr = full_instr[3:0];
  assign instr_last = (state_reg == SEP_L_INSTR) && (cnt_reg == 5'h07);
  assign data_last = (state_reg == SEP_L_DATA) && (cnt_reg == 5'(SEP_WORD_W - 1));
  assign full_is_read = (full_op[3:2] == SEP_OPC_HI_READ);
  assign full_has_data = (full_op[3:2] == SEP_OPC_HI_WRITE) || (full_op == SEP_OPC_WRITE_ALL);

  always_ff @(posedge link.serial_clock or posedge link_rst) begin
    if (link_rst) begin
      state_reg <= SEP_L_WAIT;
      cnt_reg <= 5'h00;
    end else begin
      unique case (state_reg)
        SEP_L_WAIT: begin
          // Zeros after select rises are idle clocks
          if (link.serial_in) begin
            state_reg <= SEP_L_INSTR;
            cnt_reg <= 5'h00;
          end
        end
        SEP_L_INSTR: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (instr_last) begin
            cnt_reg <= 5'h00;
            if (full_is_read) begin
              state_reg <= SEP_L_READ;
            end else if (full_has_data) begin
              state_reg <= SEP_L_DATA;
            end else begin
              state_reg <= SEP_L_DONE;
            end
          end
        end
        SEP_L_DATA: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (data_last) begin
            state_reg <= SEP_L_DONE;
          end
        end
        SEP_L_READ: begin
          cnt_reg <= cnt_reg + 5'h01;
          if (cnt_reg == 5'(SEP_WORD_W - 1)) begin
            state_reg <= SEP_L_DONE;
          end
        end
        SEP_L_DONE: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

  // Instruction and data shifters, msb first
  always_ff @(posedge link.serial_clock) begin
    if (state_reg == SEP_L_INSTR) begin
      instr_reg <= full_instr;
    end
    if (instr_last) begin
      op_reg <= full_op;
      addr_reg <= full_addr;
    end
    if (state_reg == SEP_L_DATA) begin
      data_reg <= {data_reg[SEP_WORD_W-2:0], link.serial_in};
    end
  end

  // Read path; the array only changes while select is low, so it is still here
  always_ff @(posedge link.serial_clock or posedge link_rst) begin
    if (link_rst) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b0;
      rd_shift_reg <= '0;
    end else if (instr_last && full_is_read) begin
      out_reg <= 1'b0;
      oe_reg <= 1'b1;
      rd_shift_reg <= mem_reg[full_addr];
    end else if (state_reg == SEP_L_READ) begin
      out_reg <= rd_shift_reg[SEP_WORD_W-1];
      rd_shift_reg <= {rd_shift_reg[SEP_WORD_W-2:0], 1'b0};
    end
  end

  assign link.serial_out = out_reg;
  assign link.serial_out_oe = oe_reg;

  // Marks a complete non-read instruction waiting for the select fall
  always_ff @(posedge link.serial_clock or posedge srst_in) begin
    if (srst_in) begin
      armed_reg <= 1'b0;
    end else if (!link.chip_sel) begin
      armed_reg <= armed_reg;
    end else if (state_reg == SEP_L_WAIT && link.serial_in) begin
      armed_reg <= 1'b0;
    end else if ((instr_last && !full_is_read && !full_has_data) || data_last) begin
      armed_reg <= 1'b1;
    end
  end

  // ---------------- Core side ----------------

  sep_sync #(.WIDTH(2)) u_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in({link.chip_sel, armed_reg}),
    .q_out({cs_s, armed_s})
  );

  // Opcode, address and data are stable once the armed flag has crossed
  assign op_read = (op_reg[3:2] == SEP_OPC_HI_READ);
  assign op_write = (op_reg[3:2] == SEP_OPC_HI_WRITE);
  assign op_erase = (op_reg[3:2] == SEP_OPC_HI_ERASE);
  assign op_en = (op_reg == SEP_OPC_PROG_EN);
  assign op_dis = (op_reg == SEP_OPC_PROG_DIS);
  assign op_erase_all_cmd = (op_reg == SEP_OPC_ERASE_ALL);
  assign op_write_all_cmd = (op_reg == SEP_OPC_WRITE_ALL);
  assign op_is_prog = !op_read && (op_write || op_erase || op_erase_all_cmd || op_write_all_cmd);

  // One commit per instruction, on the falling edge of select
  assign commit = cs_prev_reg && !cs_s && armed_s && !used_reg;
  assign do_prog = commit && prog_en_reg && op_is_prog;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cs_prev_reg <= 1'b0;
      used_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs_s;
      if (commit) begin
        used_reg <= 1'b1;
      end else if (!armed_s) begin
        used_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prog_en_reg <= 1'b0;
    end else if (commit && op_en) begin
      prog_en_reg <= 1'b1;
    end else if (commit && op_dis) begin
      prog_en_reg <= 1'b0;
    end
  end

  // Programming voltage only between the select fall and the next rise
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      prog_active_reg <= 1'b0;
    end else if (do_prog) begin
      prog_active_reg <= 1'b1;
    end else if (cs_s) begin
      prog_active_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      standby_reg <= 1'b1;
    end else begin
      standby_reg <= !cs_s && !prog_active_reg && !do_prog;
    end
  end

  // Array is non-volatile: no reset
  generate
    for (genvar w = 0; w < SEP_WORDS; w++) begin : g_word
      always_ff @(posedge clk_in) begin
        if (do_prog) begin
          if ((op_erase && addr_reg == SEP_ADDR_W'(w)) || op_erase_all_cmd) begin
            mem_reg[w] <= SEP_ERASED_WORD;
          end else if ((op_write && addr_reg == SEP_ADDR_W'(w)) || op_write_all_cmd) begin
            mem_reg[w] <= data_reg;
          end
        end
      end
    end
  endgenerate

  assign standby_out = standby_reg;
  assign hv_on_out = prog_active_reg;
  assign prog_en_out = prog_en_reg;
endmodule // sep_eeprom_dev

`default_nettype wire

//--- sep_host.sv
// Host end: turns one command at a time into a framed serial transfer
// Assumes clk_in at 100 MHz; the serial clock is divided from it
`timescale 1ns/10ps
`default_nettype none

module sep_host #(
  parameter int PROG_CYC = sep_pkg::SEP_TEW_CYC
) (
  sep_link_if.host link,
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic cmd_valid_in,
  output logic cmd_ready_out,
  input wire sep_pkg::sep_cmd_t cmd_op_in,
  input wire logic [3:0] cmd_addr_in,
  input wire logic [15:0] cmd_data_in,
  output logic [15:0] rd_data_out,
  output logic done_out
);
  import sep_pkg::*;

  sep_host_st_t st_reg;
  logic [23:0] timer_reg;
  logic [4:0] bit_reg;
  logic [4:0] nbits_reg;
  logic [25:0] tx_reg;
  logic [15:0] rx_reg;
  logic [15:0] rd_data_reg;
  logic sclk_reg;
  logic cs_reg;
  logic sdat_reg;
  logic is_read_reg;
  logic is_prog_reg;
  logic done_reg;
  logic do_s;
  logic half_end;
  logic [3:0] opc;
  logic with_data;

  sep_sync #(.WIDTH(1)) u_do_sync (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .d_in(link.do_line),
    .q_out(do_s)
  );

  always_comb begin
    unique case (cmd_op_in)
      SEP_CMD_READ: opc = SEP_OPC_READ;
      SEP_CMD_WRITE: opc = SEP_OPC_WRITE;
      SEP_CMD_ERASE: opc = SEP_OPC_ERASE;
      SEP_CMD_PROG_EN: opc = SEP_OPC_PROG_EN;
      SEP_CMD_PROG_DIS: opc = SEP_OPC_PROG_DIS;
      SEP_CMD_ERASE_ALL: opc = SEP_OPC_ERASE_ALL;
      default: opc = SEP_OPC_WRITE_ALL;
    endcase
  end

  assign with_data = (cmd_op_in == SEP_CMD_WRITE) || (cmd_op_in == SEP_CMD_WRITE_ALL);
  assign half_end = (timer_reg == 24'(SEP_SCLK_HALF_CYC - 1));
  assign cmd_ready_out = (st_reg == SEP_H_IDLE);

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      st_reg <= SEP_H_IDLE;
      timer_reg <= 24'h00_0000;
      bit_reg <= 5'h00;
      nbits_reg <= SEP_FRAME_SHORT;
      tx_reg <= 26'h000_0000;
      rx_reg <= 16'h0000;
      rd_data_reg <= 16'h0000;
      sclk_reg <= 1'b0;
      cs_reg <= 1'b0;
      sdat_reg <= 1'b0;
      is_read_reg <= 1'b0;
      is_prog_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      unique case (st_reg)
        SEP_H_IDLE: begin
          if (cmd_valid_in) begin
            // Lead-in zero gives the idle clock before the start bit
            tx_reg <= {1'b0, 1'b1, opc, cmd_addr_in, with_data ? cmd_data_in : 16'h0000};
            nbits_reg <= (with_data || cmd_op_in == SEP_CMD_READ) ? SEP_FRAME_LONG : SEP_FRAME_SHORT;
            is_read_reg <= (cmd_op_in == SEP_CMD_READ);
            is_prog_reg <= with_data || cmd_op_in == SEP_CMD_ERASE || cmd_op_in == SEP_CMD_ERASE_ALL;
            cs_reg <= 1'b1;
            sclk_reg <= 1'b0;
            sdat_reg <= 1'b0;
            bit_reg <= 5'h00;
            timer_reg <= 24'h00_0000;
            st_reg <= SEP_H_SHIFT;
          end
        end
        SEP_H_SHIFT: begin
          timer_reg <= timer_reg + 24'h00_0001;
          if (half_end) begin
            timer_reg <= 24'h00_0000;
            if (!sclk_reg) begin
              sclk_reg <= 1'b1;
            end else begin
              sclk_reg <= 1'b0;
              if (is_read_reg && bit_reg >= SEP_FIRST_DATA_BIT) begin
                rx_reg <= {rx_reg[14:0], do_s};
              end
              if (bit_reg == nbits_reg - 5'h01) begin
                // Clock stops here; programming needs none
                cs_reg <= 1'b0;
                sdat_reg <= 1'b0;
                st_reg <= is_prog_reg ? SEP_H_PROG : SEP_H_GAP;
              end else begin
                bit_reg <= bit_reg + 5'h01;
                tx_reg <= {tx_reg[24:0], 1'b0};
                sdat_reg <= tx_reg[24];
              end
            end
          end
        end
        SEP_H_PROG: begin
          timer_reg <= timer_reg + 24'h00_0001;
          if (timer_reg == 24'(PROG_CYC - 1)) begin
            timer_reg <= 24'h00_0000;
            cs_reg <= 1'b1;
            st_reg <= SEP_H_HIGH;
          end
        end
        SEP_H_HIGH: begin
          timer_reg <= timer_reg + 24'h00_0001;
          if (timer_reg == 24'(2 * SEP_SCLK_HALF_CYC - 1)) begin
            timer_reg <= 24'h00_0000;
            cs_reg <= 1'b0;
            st_reg <= SEP_H_GAP;
          end
        end
        SEP_H_GAP: begin
          timer_reg <= timer_reg + 24'h00_0001;
          if (timer_reg == 24'(SEP_CS_LOW_CYC - 1)) begin
            timer_reg <= 24'h00_0000;
            if (is_read_reg) begin
              rd_data_reg <= rx_reg;
            end
            done_reg <= 1'b1;
            st_reg <= SEP_H_IDLE;
          end
        end
      endcase
    end
  end

  assign link.chip_sel = cs_reg;
  assign link.serial_clock = sclk_reg;
  assign link.serial_in = sdat_reg;
  assign rd_data_out = rd_data_reg;
  assign done_out = done_reg;
endmodule // sep_host

`default_nettype wire

//--- sep_link_if.sv
// Three-wire link between host and word store, plus the data-out wire
// Assumes the bench instantiates it and hands each end its modport
`timescale 1ns/10ps
`default_nettype none

interface sep_link_if;
  logic chip_sel;
  logic serial_clock;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe;
  logic do_line;

  // Undriven data-out wire reads high, as through a pull-up
  assign do_line = serial_out_oe ? serial_out : 1'b1;

  modport dev (
    input chip_sel,
    input serial_clock,
    input serial_in,
    output serial_out,
    output serial_out_oe
  );

  modport host (
    output chip_sel,
    output serial_clock,
    output serial_in,
    input do_line
  );
endinterface

`default_nettype wire

//--- sep_link_props.sv
// Concurrent checks on the host-to-store link and on the store's status outputs
// Assumes the bench instantiates it beside the link interface, all in the clk_in domain
`timescale 1ns/10ps
`default_nettype none

module sep_link_props (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic chip_sel,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe,
  input wire logic hv_on_out,
  input wire logic standby_out
);
  import sep_pkg::*;

  localparam int SCLK_PER_CYC = SEP_SCLK_PERIOD_NS / SEP_CLK_PERIOD_NS;

  logic [15:0] sclk_gap_reg;
  logic [15:0] cs_low_reg;

  // Cycles since the last serial clock rise, saturating
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      sclk_gap_reg <= 16'hffff;
    end else if ($rose(serial_clock)) begin
      sclk_gap_reg <= 16'h0001;
    end else if (sclk_gap_reg != 16'hffff) begin
      sclk_gap_reg <= sclk_gap_reg + 16'h0001;
    end
  end

  // Length of the current deselected stretch, saturating
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      cs_low_reg <= 16'hffff;
    end else if (chip_sel) begin
      cs_low_reg <= 16'h0000;
    end else if (cs_low_reg != 16'hffff) begin
      cs_low_reg <= cs_low_reg + 16'h0001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (srst_in);

  oe_idle_a: assert property (!chip_sel |=> !serial_out_oe)
    else $error("data out driven while deselected");
  dummy_first_a: assert property ($rose(serial_out_oe) |-> $rose(serial_clock) && !serial_out)
    else $error("read did not open with a low dummy bit on a clock rise");
  out_edge_a: assert property (serial_out_oe && $past(serial_out_oe) && $changed(serial_out) |-> $rose(serial_clock))
    else $error("read bit changed away from a clock rise");
  lead_in_a: assert property ($rose(chip_sel) |-> (!serial_in && !serial_clock) [*8])
    else $error("no low lead-in period after select");
  sin_edge_a: assert property (chip_sel && $past(chip_sel) && $changed(serial_in) |-> $fell(serial_clock))
    else $error("serial input changed away from a clock fall");
  sclk_period_a: assert property ($rose(serial_clock) |-> int'(sclk_gap_reg) >= SCLK_PER_CYC)
    else $error("serial clock period too short");
  cs_gap_a: assert property ($rose(chip_sel) |-> int'(cs_low_reg) >= SEP_CS_LOW_CYC)
    else $error("select low stretch too short");
  prog_hold_a: assert property ($rose(chip_sel) && hv_on_out |-> chip_sel [*8])
    else $error("select not held high after programming");
  hv_start_a: assert property ($rose(hv_on_out) |-> !chip_sel && !$past(chip_sel))
    else $error("programming started while selected");
  hv_end_a: assert property ($rose(chip_sel) |-> ##[1:5] !hv_on_out)
    else $error("programming outlived select rise");
  standby_sel_a: assert property (chip_sel [*6] |-> !standby_out && !hv_on_out)
    else $error("standby or programming while selected");
  hv_standby_a: assert property (hv_on_out |-> !standby_out)
    else $error("standby during programming");
endmodule // sep_link_props

`default_nettype wire

//--- sep_pkg.sv
// Shared constants and types for the serial word-store link
// Assumes both ends, the link checks and the bench import this package; the link interface does not
`default_nettype none

package sep_pkg;

  // Array shape
  localparam int SEP_WORDS = 16;
  localparam int SEP_WORD_W = 16;
  localparam int SEP_ADDR_W = 4;
  localparam int SEP_OPC_W = 4;
  localparam int SEP_INSTR_BITS = 9;

  // Operation codes; the top two bits alone select read, write and erase
  localparam logic [1:0] SEP_OPC_HI_READ = 2'h2;
  localparam logic [1:0] SEP_OPC_HI_WRITE = 2'h1;
  localparam logic [1:0] SEP_OPC_HI_ERASE = 2'h3;
  localparam logic [3:0] SEP_OPC_READ = 4'h8;
  localparam logic [3:0] SEP_OPC_WRITE = 4'h4;
  localparam logic [3:0] SEP_OPC_ERASE = 4'hc;
  localparam logic [3:0] SEP_OPC_PROG_EN = 4'h3;
  localparam logic [3:0] SEP_OPC_PROG_DIS = 4'h0;
  localparam logic [3:0] SEP_OPC_ERASE_ALL = 4'h2;
  localparam logic [3:0] SEP_OPC_WRITE_ALL = 4'h1;
  localparam logic [15:0] SEP_ERASED_WORD = 16'hffff;

  // Host frame: one lead-in bit, nine instruction bits, sixteen data bits
  localparam logic [4:0] SEP_FRAME_SHORT = 5'h0a;
  localparam logic [4:0] SEP_FRAME_LONG = 5'h1a;
  localparam logic [4:0] SEP_FIRST_DATA_BIT = 5'h0a;

  // Timing
  localparam int SEP_CLK_PERIOD_NS = 10;
  localparam int SEP_SCLK_PERIOD_NS = 4000;
  localparam int SEP_TEW_MIN_MS = 10;
  localparam int SEP_TEW_MAX_MS = 30;
  localparam int SEP_CS_LOW_NS = 1000;
  localparam int SEP_SCLK_HALF_CYC = (SEP_SCLK_PERIOD_NS / SEP_CLK_PERIOD_NS + 1) / 2;
  localparam int SEP_TEW_CYC = SEP_TEW_MIN_MS * 1000000 / SEP_CLK_PERIOD_NS;
  localparam int SEP_CS_LOW_CYC = (SEP_CS_LOW_NS + SEP_CLK_PERIOD_NS - 1) / SEP_CLK_PERIOD_NS;

  typedef enum logic [2:0] {
    SEP_CMD_READ,
    SEP_CMD_WRITE,
    SEP_CMD_ERASE,
    SEP_CMD_PROG_EN,
    SEP_CMD_PROG_DIS,
    SEP_CMD_ERASE_ALL,
    SEP_CMD_WRITE_ALL
  } sep_cmd_t;

  typedef enum {SEP_L_WAIT, SEP_L_INSTR, SEP_L_DATA, SEP_L_READ, SEP_L_DONE} sep_link_st_t;

  typedef enum {SEP_H_IDLE, SEP_H_SHIFT, SEP_H_PROG, SEP_H_HIGH, SEP_H_GAP} sep_host_st_t;

endpackage

`default_nettype wire

//--- sep_sync.sv
// Two-stage level synchroniser into clk_in
// Assumes inputs are levels that stay put for several clk_in cycles
`timescale 1ns/10ps
`default_nettype none

module sep_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= d_in;
      sync_reg <= meta_reg;
    end
  end

  assign q_out = sync_reg;
endmodule // sep_sync

`default_nettype wire

//--- sep_tb_top.sv
// Bench joining host and word store over the link; drives host commands
// Assumes the sep_pkg package, the link interface and both ends are compiled first
`timescale 1ns/10ps
`default_nettype none

module sep_tb_top;
  import sep_pkg::*;

  localparam int PROG_SIM = 120;
  localparam int LIMIT = 100000;

  logic clk_in, srst_in, cmd_valid_in, cmd_ready_out, done_out, standby_out, hv_on_out, prog_en_out;
  sep_cmd_t cmd_op_in;
  logic [3:0] cmd_addr_in, a_w;
  logic [15:0] cmd_data_in, rd_data_out, d_all, d_w;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed;
  logic [15:0] shadow [16];
  logic shadow_en = 1'b0;

  // What a word holds after a command, by the rules alone
  function automatic logic [15:0] model_word(input sep_cmd_t op, input logic en, input logic hit,
    input logic [15:0] old, input logic [15:0] d);
    logic [15:0] w;
    w = old;
    if (en && (op == SEP_CMD_ERASE_ALL || (op == SEP_CMD_ERASE && hit))) begin
      w = SEP_ERASED_WORD;
    end else if (en && (op == SEP_CMD_WRITE_ALL || (op == SEP_CMD_WRITE && hit))) begin
      w = d;
    end
    return w;
  endfunction

  sep_link_if lnk();

  sep_eeprom_dev i_sep_eeprom_dev (.link(lnk), .clk_in(clk_in), .srst_in(srst_in), .standby_out(standby_out),
    .hv_on_out(hv_on_out), .prog_en_out(prog_en_out));

  sep_host #(.PROG_CYC(PROG_SIM)) i_sep_host (.link(lnk), .clk_in(clk_in), .srst_in(srst_in),
    .cmd_valid_in(cmd_valid_in), .cmd_ready_out(cmd_ready_out), .cmd_op_in(cmd_op_in), .cmd_addr_in(cmd_addr_in),
    .cmd_data_in(cmd_data_in), .rd_data_out(rd_data_out), .done_out(done_out));

  sep_link_props i_sep_link_props (.clk_in(clk_in), .srst_in(srst_in), .chip_sel(lnk.chip_sel),
    .serial_clock(lnk.serial_clock), .serial_in(lnk.serial_in), .serial_out(lnk.serial_out),
    .serial_out_oe(lnk.serial_out_oe), .hv_on_out(hv_on_out), .standby_out(standby_out));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One command through the host; afterwards the link must be idle and the store in standby
  task automatic run_cmd(input string nm, input sep_cmd_t op, input logic [3:0] a, input logic [15:0] d);
    int t;
    t = 0;
    @(negedge clk_in);
    chk({nm, " ready"}, 16'h0001, {15'h0000, cmd_ready_out});
    cmd_valid_in = 1'b1;
    cmd_op_in = op;
    cmd_addr_in = a;
    cmd_data_in = d;
    @(negedge clk_in);
    cmd_valid_in = 1'b0;
    for (int i = 0; i < 16; i++) begin
      shadow[i] = model_word(op, shadow_en, a == 4'(i), shadow[i], d);
    end
    if (op == SEP_CMD_PROG_EN) begin
      shadow_en = 1'b1;
    end else if (op == SEP_CMD_PROG_DIS) begin
      shadow_en = 1'b0;
    end
    while (done_out !== 1'b1 && t < 20000) begin
      @(negedge clk_in);
      t++;
    end
    chk({nm, " done"}, 16'h0001, {15'h0000, done_out});
    repeat (2) @(negedge clk_in);
    chk({nm, " standby"}, 16'h0001, {15'h0000, standby_out});
    chk({nm, " idle line"}, 16'h0001, {15'h0000, lnk.do_line});
    chk({nm, " enable model"}, {15'h0000, shadow_en}, {15'h0000, prog_en_out});
    $display("test %s finished", nm);
  endtask

  task automatic rd_chk(input string nm, input logic [3:0] a, input logic [15:0] exp);
    run_cmd(nm, SEP_CMD_READ, a, 16'h0000);
    chk({nm, " data"}, exp, rd_data_out);
    chk({nm, " model data"}, shadow[a], rd_data_out);
  endtask

  always @(posedge clk_in) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_fail++;
      $display("BAD timeout expected %0d seen %0d", LIMIT - 1, cyc);
      conclude();
    end
  end

  initial begin
    seed = 32'h75d0_864f;
    srst_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_op_in = SEP_CMD_READ;
    cmd_addr_in = 4'h0;
    cmd_data_in = 16'h0000;
    a_w = 4'($random(seed));
    d_all = 16'($random(seed));
    d_w = 16'($random(seed));
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    srst_in = 1'b0;
    chk("standby after reset", 16'h0001, {15'h0000, standby_out});
    chk("enable after reset", 16'h0000, {15'h0000, prog_en_out});
    run_cmd("enable", SEP_CMD_PROG_EN, 4'h5, 16'h0000);
    chk("enable flag", 16'h0001, {15'h0000, prog_en_out});
    run_cmd("erase all", SEP_CMD_ERASE_ALL, 4'h0, 16'h0000);
    run_cmd("write all", SEP_CMD_WRITE_ALL, 4'h0, d_all);
    rd_chk("read top word", 4'hf, d_all);
    run_cmd("erase word", SEP_CMD_ERASE, a_w, 16'h0000);
    rd_chk("read erased", a_w, SEP_ERASED_WORD);
    run_cmd("write word", SEP_CMD_WRITE, a_w, d_w);
    rd_chk("read written", a_w, d_w);
    run_cmd("disable", SEP_CMD_PROG_DIS, 4'ha, 16'h0000);
    chk("disable flag", 16'h0000, {15'h0000, prog_en_out});
    run_cmd("refused write", SEP_CMD_WRITE, a_w, ~d_w);
    rd_chk("read after refusal", a_w, d_w);
    conclude();
  end
endmodule // sep_tb_top

`default_nettype wire
